/* File: rtl/cwd_pkg.sv */
package cwd_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned MS_PER_S         = 1000;
  // Shortest power-up delay; longer codes double it
  localparam int unsigned POWERUP_DELAY_TIMER_BASE_MS     = 2;
  localparam int unsigned POWERUP_DELAY_TIMER_BASE_CYC    = POWERUP_DELAY_TIMER_BASE_MS * (CLK_HZ / MS_PER_S);
  localparam int          POWERUP_DELAY_TIMER_CNT_W       = 25;

  localparam logic [11:0] ADDR_WDOG_CFG    = 12'h000;
  localparam logic [11:0] ADDR_AUX_CFG     = 12'h004;
  localparam logic [11:0] ADDR_RESET_CFG   = 12'h008;
  localparam logic [11:0] ADDR_CTRL        = 12'h00C;
  localparam logic [11:0] ADDR_STATUS      = 12'h010;

  // Erased-flash style defaults: all ones except the aux key, which is 00 so the key stays consistent
  localparam logic [6:0]  WDOG_CFG_RST     = 7'h7F;
  localparam logic [3:0]  AUX_CFG_RST      = 4'h3;
  localparam logic [2:0]  RESET_CFG_RST    = 3'h7;

  localparam int          CTRL_BULK_ERASE  = 0;
  localparam int          CTRL_WDOG_CLEAR  = 1;
  localparam logic [1:0]  KEY_OPEN         = 2'h0;
  localparam logic [1:0]  KEY_OTHER        = 2'h3;

  localparam logic [6:0]  PRE_TERM_32      = 7'h1F;
  localparam logic [6:0]  PRE_TERM_128     = 7'h7F;

  typedef struct packed {
    logic [3:0] postscale_sel;
    logic       prescale_sel;
    logic       lock_wait_enable;
    logic       window_disable;
  } cwd_wdog_cfg_t;

  typedef struct packed {
    logic [1:0] segment_key;
    logic       write_protect_n;
    logic       code_protect_n;
  } cwd_aux_cfg_t;

  function automatic logic [15:0] cwd_post_ratio(input logic [3:0] sel);
    cwd_post_ratio = 16'h0001 << sel;
  endfunction

  function automatic logic [6:0] cwd_pre_term(input logic sel);
    cwd_pre_term = sel ? PRE_TERM_128 : PRE_TERM_32;
  endfunction
endpackage

/* File: rtl/cwd_top.sv */
`timescale 1ns/1ps
// How it works
// - Window-disable 1 non-window, 0 window mode
// - Lock-wait holds PLL switch until lock
// - Prescale bit: 1 gives 1:128, 0 gives 1:32
// - Postscale code selects power-of-two ratio
// - Key mismatch forces auxiliary code protection
// - Forced lock stays until bulk erase
// - Code-protect bit 0 protects auxiliary memory
// - Write-protect bit 0 blocks auxiliary writes
// - Codes 111/110/101 give 128/64/32 ms
// - Lower codes halve; code 000 disables
module cwd_top
  import cwd_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_BASE_CYCLES = POWERUP_DELAY_TIMER_BASE_CYC
)(
  input  wire logic        pclk,             // APB clock
  input  wire logic        presetn,          // Async reset, low
  input  wire logic [11:0] paddr,            // APB address
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  input  wire logic        wdog_tick,        // Watchdog base tick
  input  wire logic        clk_switch_req,   // Request switch to PLL
  input  wire logic        pll_lock,         // PLL lock valid
  output logic             pll_selected,     // PLL is clock source
  output logic             clk_switch_wait,  // Switch held for lock
  output logic             wdog_reset,       // Watchdog reset pulse
  output logic             aux_code_protected, // Aux segment read-locked
  output logic             aux_write_blocked,  // Aux segment write-locked
  output logic             powerup_done      // Power-up delay over
);
  cwd_wdog_cfg_t   wcfg_q;
  cwd_aux_cfg_t    acfg_q;
  cwd_aux_cfg_t    acfg_d;
  logic [2:0]      powerup_delay_timer_sel_q;
  logic [31:0]     prdata_q;
  logic            lock_q;
  logic            lock_d;
  logic            cp_q;
  logic            wb_q;
  logic            pll_q;
  logic            done_q;
  logic [POWERUP_DELAY_TIMER_CNT_W-1:0] cnt_q;

  wire setup    = psel & ~penable;
  wire wr       = psel & penable & pwrite;
  wire sel_wdog = (paddr == ADDR_WDOG_CFG);
  wire sel_aux  = (paddr == ADDR_AUX_CFG);
  wire sel_rst  = (paddr == ADDR_RESET_CFG);
  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_stat = (paddr == ADDR_STATUS);
  wire mapped   = sel_wdog | sel_aux | sel_rst | sel_ctrl | sel_stat;
  wire erase    = wr & sel_ctrl & pwdata[CTRL_BULK_ERASE];
  wire wd_clear = wr & sel_ctrl & pwdata[CTRL_WDOG_CLEAR];
  // Aux settings frozen while forced lock stands
  wire aux_wr   = wr & sel_aux & ~lock_q;

  // Key expected from the two settings
  function automatic logic cwd_key_bad(input cwd_aux_cfg_t c);
    cwd_key_bad = c.segment_key !=
                  ((c.code_protect_n & c.write_protect_n) ? KEY_OPEN : KEY_OTHER);
  endfunction

  // Erase reloads a consistent word; judging the next word lets it unlock
  assign acfg_d = erase  ? cwd_aux_cfg_t'(AUX_CFG_RST) :
                  aux_wr ? cwd_aux_cfg_t'(pwdata[3:0]) : acfg_q;

  wire       mismatch = cwd_key_bad(acfg_q);

  assign lock_d = cwd_key_bad(acfg_d) | (lock_q & ~erase);

  wire [POWERUP_DELAY_TIMER_CNT_W-1:0] base_cyc = POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_BASE_CYCLES);
  wire [POWERUP_DELAY_TIMER_CNT_W-1:0] powerup_delay_timer_cyc = (powerup_delay_timer_sel_q == 3'h0) ? '0 :
                                   POWERUP_DELAY_TIMER_CNT_W'(base_cyc << (powerup_delay_timer_sel_q - 3'h1));

  wire sw_ok = ~wcfg_q.lock_wait_enable | pll_lock;

  wire [31:0] rd_mux =
      sel_wdog ? {25'h0, wcfg_q} :
      sel_aux  ? {28'h0, acfg_q} :
      sel_rst  ? {29'h0, powerup_delay_timer_sel_q} :
      sel_stat ? {26'h0, pll_q, done_q, lock_q, wb_q, cp_q, ~wcfg_q.window_disable} :
                 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcfg_q     <= WDOG_CFG_RST;
      powerup_delay_timer_sel_q <= RESET_CFG_RST;
      prdata_q   <= 32'h0;
    end else begin
      if (wr & sel_wdog) begin
        wcfg_q <= pwdata[6:0];
      end
      if (wr & sel_rst) begin
        powerup_delay_timer_sel_q <= pwdata[2:0];
      end
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acfg_q <= AUX_CFG_RST;
      lock_q <= 1'b0;
    end else begin
      acfg_q <= acfg_d;
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_q <= 1'b1;
      wb_q <= 1'b1;
    end else begin
      cp_q <= ~acfg_q.code_protect_n | mismatch | lock_q;
      wb_q <= ~acfg_q.write_protect_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_q  <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      if (clk_switch_req & sw_ok) begin
        pll_q <= 1'b1;
      end
      if (!done_q) begin
        done_q <= (cnt_q >= powerup_delay_timer_cyc);
        cnt_q  <= POWERUP_DELAY_TIMER_CNT_W'(cnt_q + 1'b1);
      end
    end
  end

  cwd_wdog u_wdog (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (wdog_tick),
    .clear      (wd_clear),
    .cfg        (wcfg_q),
    .wdog_reset (wdog_reset)
  );

  assign pready             = 1'b1;
  assign pslverr            = psel & penable & ~mapped;
  assign prdata             = prdata_q;
  assign pll_selected       = pll_q;
  assign clk_switch_wait    = clk_switch_req & ~pll_q & ~sw_ok;
  assign aux_code_protected = cp_q;
  assign aux_write_blocked  = wb_q;
  assign powerup_done       = done_q;

  property p_lock_wait;
    @(posedge pclk) disable iff (!presetn)
      (!pll_q && wcfg_q.lock_wait_enable && !pll_lock) |=> !pll_q;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("switch before lock");

  property p_no_wait;
    @(posedge pclk) disable iff (!presetn)
      (clk_switch_req && !wcfg_q.lock_wait_enable) |=> pll_q;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("switch waited needlessly");

  property p_mismatch;
    @(posedge pclk) disable iff (!presetn)
      (mismatch && !erase) |=> lock_q && aux_code_protected;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not protected");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      (lock_q && !erase) |=> lock_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock released without erase");

  property p_cp;
    @(posedge pclk) disable iff (!presetn)
      !acfg_q.code_protect_n |=> aux_code_protected;
  endproperty
  a_cp: assert property (p_cp) else $error("code protect ignored");

  property p_wb;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> aux_write_blocked == !$past(acfg_q.write_protect_n);
  endproperty
  a_wb: assert property (p_wb) else $error("write protect wrong");

  property p_powerup_delay_timer_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(done_q) |-> $past(cnt_q) >= $past(powerup_delay_timer_cyc) && $past(cnt_q, 2) < $past(powerup_delay_timer_cyc, 2);
  endproperty
  a_powerup_delay_timer_len: assert property (p_powerup_delay_timer_len) else $error("power-up delay length wrong");

  property p_powerup_delay_timer_off;
    @(posedge pclk) disable iff (!presetn)
      (powerup_delay_timer_sel_q == 3'h0) |=> powerup_done;
  endproperty
  a_powerup_delay_timer_off: assert property (p_powerup_delay_timer_off) else $error("disabled delay not skipped");

  c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_q));
  c_erase: cover property (@(posedge pclk) disable iff (!presetn) lock_q && erase);
  c_wait: cover property (@(posedge pclk) disable iff (!presetn) clk_switch_wait ##1 pll_q);
endmodule // cwd_top

/* File: rtl/cwd_wdog.sv */
`timescale 1ns/1ps
module cwd_wdog
  import cwd_pkg::*;
(
  input  wire logic          pclk,       // Clock
  input  wire logic          presetn,    // Async reset, low
  input  wire logic          tick,       // Base watchdog clock tick
  input  wire logic          clear,      // Software service pulse
  input  wire cwd_wdog_cfg_t cfg,        // Watchdog settings
  output logic               wdog_reset  // Timeout or early service
);
  logic [6:0]  pre_q;
  logic [6:0]  pre_d;
  logic [14:0] post_q;
  logic [14:0] post_d;
  logic        rst_q;
  wire  [15:0] ratio    = cwd_post_ratio(cfg.postscale_sel);
  wire  [14:0] post_end = 15'(ratio - 16'h0001);
  wire         pre_end  = (pre_q == cwd_pre_term(cfg.prescale_sel));
  wire         expire   = tick & pre_end & (post_q == post_end);
  // Window opens at half the postscaled period
  wire         win_open = ({1'b0, post_q} >= (ratio >> 1));
  wire         early    = clear & ~cfg.window_disable & ~win_open;

  assign pre_d  = (clear | expire | (tick & pre_end)) ? 7'h00 : 7'(pre_q + {6'h00, tick});
  assign post_d = (clear | expire) ? 15'h0000 :
                  (tick & pre_end) ? 15'(post_q + 15'h0001) : post_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= 7'h00;
      post_q <= 15'h0000;
      rst_q  <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      post_q <= post_d;
      rst_q  <= expire | early;
    end
  end
  assign wdog_reset = rst_q;

  property p_win_early;
    @(posedge pclk) disable iff (!presetn)
      (clear && !cfg.window_disable && post_q < ratio[15:1]) |=> wdog_reset;
  endproperty
  a_win_early: assert property (p_win_early) else $error("early service missed");

  property p_nowin;
    @(posedge pclk) disable iff (!presetn)
      (clear && cfg.window_disable && !expire) |=> !wdog_reset;
  endproperty
  a_nowin: assert property (p_nowin) else $error("service reset in non-window");

  property p_pre_ratio;
    @(posedge pclk) disable iff (!presetn)
      (tick && pre_q == 7'h1F && !clear) |=> (cfg.prescale_sel ? pre_q == 7'h20 : pre_q == 7'h00);
  endproperty
  a_pre_ratio: assert property (p_pre_ratio) else $error("prescale wrap wrong");

  property p_post_ratio;
    @(posedge pclk) disable iff (!presetn)
      wdog_reset && !$past(clear) |-> $past(post_q) == 15'($past(ratio) - 16'h0001);
  endproperty
  a_post_ratio: assert property (p_post_ratio) else $error("postscale ratio wrong");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      $rose(wdog_reset) && !$past(clear) |-> $past(tick) && $past(pre_end);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not at product");

  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) expire);
  c_early: cover property (@(posedge pclk) disable iff (!presetn) early);
endmodule // cwd_wdog

/* File: test/cwd_top_tb.sv */
`timescale 1ns/1ps
module cwd_top_tb;
  import cwd_pkg::*;
  localparam int unsigned BASE = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        wdog_tick = 1'b0, clk_switch_req = 1'b0, pll_lock = 1'b0;
  logic        pll_selected, clk_switch_wait, wdog_reset;
  logic        aux_code_protected, aux_write_blocked, powerup_done;
  int          fails = 0, n_compared = 0, cyc = 0, n_pulse = 0, t0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // Sticky count, so a pulse inside a bus transfer is not missed
  always @(posedge pclk) if (wdog_reset === 1'b1) n_pulse <= n_pulse + 1;

  cwd_top #(.POWERUP_DELAY_TIMER_BASE_CYCLES(BASE)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdog_tick(wdog_tick), .clk_switch_req(clk_switch_req),
    .pll_lock(pll_lock), .pll_selected(pll_selected), .clk_switch_wait(clk_switch_wait),
    .wdog_reset(wdog_reset), .aux_code_protected(aux_code_protected),
    .aux_write_blocked(aux_write_blocked), .powerup_done(powerup_done));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask

  // Waits at falling edges, where registered outputs are settled
  task automatic wait_sig(input int s, input int lim);
    int   n;
    logic v;
    n = 0;
    v = 1'b0;
    do begin
      @(negedge pclk);
      n++;
      v = (s == 0) ? powerup_done : (s == 1) ? wdog_reset : pll_selected;
    end while (v !== 1'b1 && n < lim);
    if (v !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    @(posedge pclk);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_WDOG_CFG, 32'h0);
    chk("wdog cfg", rd, 32'h7F);
    apb(1'b0, ADDR_AUX_CFG, 32'h0);
    chk("aux cfg", rd, 32'h3);
    apb(1'b0, ADDR_RESET_CFG, 32'h0);
    chk("reset cfg", rd, 32'h7);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd & 32'hF, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_aux();
    logic [3:0] v[4] = '{4'hE, 4'hD, 4'hC, 4'h3};
    logic [3:0] bad[2] = '{4'hF, 4'h2};
    foreach (v[i]) begin
      // Consistent key per protection pair
      apb(1'b1, ADDR_AUX_CFG, {28'h0, v[i]});
      repeat (2) @(posedge pclk);
      chk("code prot", {31'h0, aux_code_protected}, {31'h0, ~v[i][0]});
      chk("write blk", {31'h0, aux_write_blocked}, {31'h0, ~v[i][1]});
    end
    foreach (bad[i]) begin
      apb(1'b1, ADDR_AUX_CFG, {28'h0, bad[i]});
      repeat (3) @(posedge pclk);
      chk("forced prot", {31'h0, aux_code_protected}, 32'h1);
      apb(1'b1, ADDR_AUX_CFG, 32'h3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("lock held", rd & 32'h8, 32'h8);
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("lock erased", rd & 32'hA, 32'h0);
      apb(1'b0, ADDR_AUX_CFG, 32'h0);
      chk("aux reload", rd, 32'h3);
    end
    $display("test aux done");
  endtask

  task automatic t_clk();
    clk_switch_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("held", {pll_selected, clk_switch_wait}, 32'h1);
    pll_lock <= 1'b1;
    wait_sig(2, 3);
    @(posedge pclk);
    chk("wait off", {31'h0, clk_switch_wait}, 32'h0);
    clk_switch_req <= 1'b0;
    pll_lock <= 1'b0;
    do_reset();
    apb(1'b1, ADDR_WDOG_CFG, 32'h7D);
    clk_switch_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("no wait", {31'h0, pll_selected}, 32'h1);
    clk_switch_req <= 1'b0;
    $display("test clock switch done");
  endtask

  task automatic t_wdog();
    int pre[4] = '{0, 1, 0, 1};
    int post[4] = '{0, 0, 3, 2};
    int e;
    int p;
    wdog_tick <= 1'b1;
    foreach (pre[i]) begin
      e = (pre[i] != 0 ? 128 : 32) << post[i];
      apb(1'b1, ADDR_WDOG_CFG, 32'(post[i] * 8 + pre[i] * 4 + 3));
      wait_sig(1, 1200);
      p = cyc;
      @(posedge pclk);
      wait_sig(1, 1200);
      @(posedge pclk);
      chk("wdog period", 32'(cyc - p - 1 >= e - 1 && cyc - p - 1 <= e + 1), 32'h1);
    end
    wdog_tick <= 1'b0;
    for (int w = 0; w < 2; w++) begin
      // Postscale 1:2 so the window is still shut right after service
      apb(1'b1, ADDR_WDOG_CFG, 32'(10 + w));
      p = n_pulse;
      apb(1'b1, ADDR_CTRL, 32'h2);
      repeat (3) @(posedge pclk);
      chk("early service", 32'(n_pulse - p), 32'(1 - w));
    end
    $display("test watchdog done");
  endtask

  task automatic t_pwr();
    int e;
    for (int c = 0; c < 8; c++) begin
      e = (c == 0) ? 0 : int'(BASE) << (c - 1);
      do_reset();
      apb(1'b1, ADDR_RESET_CFG, 32'(c));
      wait_sig(0, 600);
      chk("pwr delay", 32'(cyc - t0 >= e && cyc - t0 <= e + 6), 32'h1);
      @(posedge pclk);
    end
    $display("test power-up done");
  endtask

  initial begin
    do_reset();
    t_regs();
    t_aux();
    do_reset();
    t_clk();
    t_wdog();
    t_pwr();
    print_verdict();
  end
endmodule // cwd_top_tb
